// ---- emb_pkg.sv ----
package emb_pkg;
	// Register map of the block
	localparam int REG_AW = 4;
	localparam logic [3:0] BUS_CTRL_OFS = 4'h0;
	localparam logic [7:0] BUS_CTRL_RST = 8'h00;
	// Implemented bits: 7, 5, 4, 1, 0; bits 6, 3, 2 read as zero
	localparam logic [7:0] BUS_CTRL_MASK = 8'hB3;
	// Field positions inside external_bus_control
	localparam int BUS_DISABLE_POS = 7;
	localparam int WAIT_HI_POS = 5;
	localparam int WAIT_LO_POS = 4;
	localparam int STYLE_HI_POS = 1;
	localparam int STYLE_LO_POS = 0;
	// Table write styles
	localparam logic [1:0] STYLE_BYTE_SELECT = 2'h1;
	localparam logic [1:0] STYLE_BYTE_WRITE = 2'h0;
	// Clocks of clk per instruction cycle
	localparam int CLKS_PER_TCY = 4;
	// Control strobe positions on the control port
	localparam int CTL_LATCH = 0;
	localparam int CTL_OUTEN = 1;
	localparam int CTL_WR_LO = 2;
	localparam int CTL_WR_HI = 3;
	localparam int CTL_BYTE_ADDR = 4;
	localparam int CTL_CHIP = 5;
	localparam int CTL_LO_BYTE = 6;
	localparam int CTL_UP_BYTE = 7;
	// Idle level of the strobes: active-low ones high, latch and byte addr low
	localparam logic [7:0] CTL_IDLE = 8'hEE;
	// Program memory modes, fixed by configuration
	typedef enum logic [1:0] {
		EMB_MODE_MCU,
		EMB_MODE_MPU,
		EMB_MODE_BOOT,
		EMB_MODE_EXT
	} emb_mode_e;
	// Kinds of external access
	typedef enum logic [1:0] {
		EMB_ACC_FETCH,
		EMB_ACC_TBLRD,
		EMB_ACC_TABLE_WRITE_INSTR
	} emb_acc_e;
endpackage

// ---- emb_ext_bus.sv ----
// The register addresses and the address-and-strobe port were left to the implementer.
module emb_ext_bus #(
	parameter int TCY_CLKS = emb_pkg::CLKS_PER_TCY
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration and processor state
	input wire emb_pkg::emb_mode_e mode_cfg,
	input wire logic exec_external,
	input wire logic sleep,
	// Register port
	input wire logic [emb_pkg::REG_AW-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	// Access requests from the core
	input wire logic req_valid,
	input wire emb_pkg::emb_acc_e req_kind,
	input wire logic [20:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic req_ready,
	output logic req_done,
	output logic [15:0] rsp_data,
	// Multiplexed address/data lines
	input wire logic [15:0] muxed_addr_data_in,
	output logic [15:0] muxed_addr_data_out,
	output logic [15:0] muxed_addr_data_oe_n,
	// Upper address lines
	output logic [3:0] upper_addr_out,
	output logic [3:0] upper_addr_oe_n,
	// Control strobes
	output logic [7:0] ctl_out,
	output logic [7:0] ctl_oe_n,
	// Pins handed to the port logic
	output logic pins_are_port
);
	import emb_pkg::*;

	typedef enum logic [1:0] {
		EMB_ST_IDLE,
		EMB_ST_ADDR,
		EMB_ST_DATA
	} emb_state_e;

	if (TCY_CLKS < 1 || TCY_CLKS > 256) begin : g_chk
		$error("TCY_CLKS must be between 1 and 256");
	end

	// Wait field code 11 gives no extra cycles, 00 gives three
	function automatic logic [1:0] wait_count(input logic [1:0] code);
		return ~code;
	endfunction

	logic [7:0] div_q;
	logic tcy_q;
	emb_mode_e mode_q;
	logic cfg_ok_q;
	logic [7:0] ctrl_q;
	logic [7:0] rdata_q;
	logic dis_eff_q;
	emb_state_e st_q;
	emb_acc_e acc_q;
	logic [19:0] addr_q;
	logic lsb_q;
	logic [7:0] data_q;
	logic [7:0] hold_q;
	logic [1:0] wait_q;
	logic done_q;
	logic [15:0] rsp_q;
	logic ready_q;
	logic take;
	logic shared;
	logic bus_fn;
	logic [1:0] style;
	logic [15:0] ad_o_d;
	logic [15:0] ad_oe_d;
	logic [3:0] up_o_d;
	logic [3:0] up_oe_d;
	logic [7:0] ctl_o_d;
	logic [7:0] ctl_oe_d;
	logic [15:0] ad_o_q;
	logic [15:0] ad_oe_q;
	logic [3:0] up_o_q;
	logic [3:0] up_oe_q;
	logic [7:0] ctl_o_q;
	logic [7:0] ctl_oe_q;
	logic port_q;

	assign style = ctrl_q[STYLE_HI_POS:STYLE_LO_POS];
	assign shared = (mode_q == EMB_MODE_BOOT) || (mode_q == EMB_MODE_EXT);
	assign take = req_valid && ready_q && tcy_q && (st_q == EMB_ST_IDLE);

	// Instruction cycle enable
	always_ff @(posedge clk) begin
		if (rst) begin
			div_q <= 8'h00;
			tcy_q <= 1'b0;
		end else if (div_q == 8'(TCY_CLKS - 1)) begin
			div_q <= 8'h00;
			tcy_q <= 1'b1;
		end else begin
			div_q <= div_q + 8'h01;
			tcy_q <= 1'b0;
		end
	end

	// Mode strap caught once after reset; software has no path to it
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= EMB_MODE_MCU;
			cfg_ok_q <= 1'b0;
		end else if (!cfg_ok_q) begin
			mode_q <= mode_cfg;
			cfg_ok_q <= 1'b1;
		end
	end

	// Bus control register
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= BUS_CTRL_RST;
		end else if (reg_we && reg_addr == BUS_CTRL_OFS && cfg_ok_q &&
				mode_q != EMB_MODE_MCU) begin
			ctrl_q <= reg_wdata & BUS_CTRL_MASK;
		end
	end

	// Unmapped addresses and idle cycles read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (reg_re && reg_addr == BUS_CTRL_OFS) begin
			rdata_q <= ctrl_q & BUS_CTRL_MASK;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// Disable only takes hold while running from internal memory
	always_ff @(posedge clk) begin
		if (rst) begin
			dis_eff_q <= 1'b0;
		end else if (!exec_external) begin
			dis_eff_q <= ctrl_q[BUS_DISABLE_POS];
		end
	end

	// Pin function selection
	always_comb begin
		bus_fn = 1'b0;
		if (mode_q == EMB_MODE_MPU) begin
			bus_fn = 1'b1;
		end else if (shared) begin
			bus_fn = !dis_eff_q || exec_external ||
				st_q != EMB_ST_IDLE;
		end
	end

	// Bus cycle sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= EMB_ST_IDLE;
			acc_q <= EMB_ACC_FETCH;
			addr_q <= 20'h0_0000;
			lsb_q <= 1'b0;
			data_q <= 8'h00;
			wait_q <= 2'h0;
		end else begin
			case (st_q)
				EMB_ST_IDLE: begin
					if (take) begin
						acc_q <= req_kind;
						addr_q <= req_addr[20:1];
						lsb_q <= req_addr[0];
						data_q <= req_wdata;
						st_q <= EMB_ST_ADDR;
					end
				end
				EMB_ST_ADDR: begin
					if (tcy_q) begin
						st_q <= EMB_ST_DATA;
						if (acc_q == EMB_ACC_FETCH) begin
							wait_q <= 2'h0;
						end else begin
							wait_q <= wait_count(
								ctrl_q[WAIT_HI_POS:WAIT_LO_POS]);
						end
					end
				end
				EMB_ST_DATA: begin
					// Waits stretch the data phase only
					if (tcy_q) begin
						if (wait_q != 2'h0) begin
							wait_q <= wait_q - 2'h1;
						end else begin
							st_q <= EMB_ST_IDLE;
						end
					end
				end
				default: begin
					st_q <= EMB_ST_IDLE;
				end
			endcase
		end
	end

	// Completion, read data and the even-byte holding latch
	always_ff @(posedge clk) begin
		if (rst) begin
			done_q <= 1'b0;
			rsp_q <= 16'h0000;
			hold_q <= 8'h00;
		end else begin
			done_q <= 1'b0;
			if (st_q == EMB_ST_DATA && tcy_q && wait_q == 2'h0) begin
				done_q <= 1'b1;
				if (acc_q != EMB_ACC_TABLE_WRITE_INSTR) begin
					rsp_q <= muxed_addr_data_in;
				end else if (style[1] && !lsb_q) begin
					hold_q <= data_q;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= st_q == EMB_ST_IDLE && !take && cfg_ok_q &&
				mode_q != EMB_MODE_MCU && !sleep && !done_q;
		end
	end

	// Next pin levels
	always_comb begin
		ad_o_d = 16'h0000;
		ad_oe_d = 16'hFFFF;
		up_o_d = 4'h0;
		up_oe_d = 4'hF;
		ctl_o_d = CTL_IDLE;
		ctl_oe_d = bus_fn ? 8'h00 : 8'hFF;
		if (bus_fn && st_q != EMB_ST_IDLE) begin
			up_o_d = addr_q[19:16];
			up_oe_d = 4'h0;
			ctl_o_d[CTL_CHIP] = 1'b0;
			ctl_o_d[CTL_BYTE_ADDR] = lsb_q;
			if (st_q == EMB_ST_ADDR) begin
				ad_o_d = addr_q[15:0];
				ad_oe_d = 16'h0000;
				ctl_o_d[CTL_LATCH] = 1'b1;
			end else if (acc_q != EMB_ACC_TABLE_WRITE_INSTR) begin
				ctl_o_d[CTL_OUTEN] = 1'b0;
			end else if (style[1]) begin
				// Even byte only parks in the latch; bus stays released
				if (lsb_q) begin
					ad_o_d = {data_q, hold_q};
					ad_oe_d = 16'h0000;
					ctl_o_d[CTL_WR_HI] = 1'b0;
					ctl_o_d[CTL_UP_BYTE] = 1'b0;
					ctl_o_d[CTL_LO_BYTE] = 1'b0;
				end
			end else if (style == STYLE_BYTE_SELECT) begin
				ad_o_d = {data_q, data_q};
				ad_oe_d = 16'h0000;
				ctl_o_d[CTL_WR_HI] = 1'b0;
				if (lsb_q) begin
					ctl_o_d[CTL_UP_BYTE] = 1'b0;
				end else begin
					ctl_o_d[CTL_LO_BYTE] = 1'b0;
				end
			end else begin
				ad_o_d = {data_q, data_q};
				ad_oe_d = 16'h0000;
				if (lsb_q) begin
					ctl_o_d[CTL_WR_HI] = 1'b0;
				end else begin
					ctl_o_d[CTL_WR_LO] = 1'b0;
				end
			end
		end
		if (sleep) begin
			ctl_o_d[CTL_CHIP] = 1'b1;
		end
	end

	// Pins leave from flip-flops, one clk behind the sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			ad_o_q <= 16'h0000;
			ad_oe_q <= 16'hFFFF;
			up_o_q <= 4'h0;
			up_oe_q <= 4'hF;
			ctl_o_q <= CTL_IDLE;
			ctl_oe_q <= 8'hFF;
			port_q <= 1'b1;
		end else begin
			ad_o_q <= ad_o_d;
			ad_oe_q <= ad_oe_d;
			up_o_q <= up_o_d;
			up_oe_q <= up_oe_d;
			ctl_o_q <= ctl_o_d;
			ctl_oe_q <= ctl_oe_d;
			port_q <= !bus_fn;
		end
	end

	assign reg_rdata = rdata_q;
	assign req_ready = ready_q;
	assign req_done = done_q;
	assign rsp_data = rsp_q;
	assign muxed_addr_data_out = ad_o_q;
	assign muxed_addr_data_oe_n = ad_oe_q;
	assign upper_addr_out = up_o_q;
	assign upper_addr_oe_n = up_oe_q;
	assign ctl_out = ctl_o_q;
	assign ctl_oe_n = ctl_oe_q;
	assign pins_are_port = port_q;
endmodule

// ---- emb_ext_bus_props.sv ----
module emb_ext_bus_props #(
	parameter int TCY_CLKS = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Core side
	input wire emb_pkg::emb_mode_e mode_cfg,
	input wire logic sleep,
	input wire logic [7:0] reg_rdata,
	input wire logic req_done,
	// Bus pins
	input wire logic [15:0] muxed_addr_data_out,
	input wire logic [15:0] muxed_addr_data_oe_n,
	input wire logic [7:0] ctl_out,
	input wire logic [7:0] ctl_oe_n,
	input wire logic pins_are_port
);
	import emb_pkg::*;
	logic [2:0] age_q;
	logic [8:0] lat_q;
	// Mode strap is only valid a few edges after reset
	always_ff @(posedge clk) begin
		if (rst)
			age_q <= 3'h0;
		else if (age_q != 3'h7)
			age_q <= age_q + 3'h1;
	end
	always_ff @(posedge clk) begin
		lat_q <= ctl_out[CTL_LATCH] ? lat_q + 9'h001 : 9'h000;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	mpu_bus_a: assert property (
		age_q > 3'h3 && mode_cfg == EMB_MODE_MPU |->
		!pins_are_port && ctl_oe_n == 8'h00) else $error("bus not active");
	mcu_ports_a: assert property (
		age_q > 3'h3 && mode_cfg == EMB_MODE_MCU |->
		pins_are_port && ctl_oe_n == 8'hFF) else $error("pins not ports");
	port_release_a: assert property (
		pins_are_port |-> ctl_oe_n == 8'hFF && &muxed_addr_data_oe_n)
		else $error("port pins still driven");
	// Pins lag the sequencer, so idle shows the cycle after done
	idle_after_a: assert property (
		req_done |=> ctl_out == CTL_IDLE && &muxed_addr_data_oe_n)
		else $error("bus not idle at done");
	latch_len_a: assert property (
		$fell(ctl_out[CTL_LATCH]) |-> lat_q == 9'(TCY_CLKS)
		&& !ctl_out[CTL_CHIP]) else $error("latch phase length");
	sleep_chip_a: assert property (
		sleep |=> ctl_out[CTL_CHIP]) else $error("chip select in sleep");
	write_hold_a: assert property (
		!ctl_out[CTL_WR_HI] && $past(ctl_out[CTL_WR_HI]) == 1'b0 |->
		$stable(muxed_addr_data_out)) else $error("write data moved");
	byte_copy_a: assert property (
		!ctl_out[CTL_WR_LO] |->
		muxed_addr_data_out[15:8] == muxed_addr_data_out[7:0])
		else $error("byte not copied");
	reserved_zero_a: assert property (
		(reg_rdata & 8'h4C) == 8'h00) else $error("reserved bits set");
endmodule

bind emb_ext_bus emb_ext_bus_props #(.TCY_CLKS(TCY_CLKS)) u_props (
	.clk(clk),
	.rst(rst),
	.mode_cfg(mode_cfg),
	.sleep(sleep),
	.reg_rdata(reg_rdata),
	.req_done(req_done),
	.muxed_addr_data_out(muxed_addr_data_out),
	.muxed_addr_data_oe_n(muxed_addr_data_oe_n),
	.ctl_out(ctl_out),
	.ctl_oe_n(ctl_oe_n),
	.pins_are_port(pins_are_port)
);

// ---- emb_mem_model.sv ----
module emb_mem_model (
	// Bus pins seen by the memory
	input wire logic clk,
	input wire logic [15:0] ad_out,
	input wire logic [7:0] ctl_out,
	// Lines the memory drives
	output logic [15:0] ad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import emb_pkg::*;
	logic [15:0] adr_q;
	initial ad_in = 16'h0000;
	always @(posedge clk) begin
		if (ctl_out[CTL_LATCH])
			adr_q <= ad_out;
	end
	// Released lines toggle so stale data can never pass for a read
	always @(posedge clk) begin
		if (!ctl_out[CTL_OUTEN] && !ctl_out[CTL_CHIP])
			ad_in <= ~adr_q;
		else
			ad_in <= ~ad_in;
	end
endmodule

// ---- emb_ext_bus_tb.sv ----
module emb_ext_bus_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import emb_pkg::*;
	logic clk, rst, exec_external, sleep, reg_we, reg_re, req_valid;
	logic req_ready, req_done, pins_are_port, oe_or;
	emb_mode_e mode_cfg;
	emb_acc_e req_kind;
	logic [3:0] reg_addr, upper_addr_out, upper_addr_oe_n;
	logic [7:0] reg_wdata, reg_rdata, req_wdata, ctl_out, ctl_oe_n, c_and;
	logic [7:0] up_s;
	logic [20:0] req_addr;
	logic [15:0] rsp_data, ad_out, ad_oe_n, m_ad, ad_w, w_ad;
	logic [3:0] exp_s [6] = '{4'hE, 4'hD, 4'h9, 4'h5, 4'hF, 4'h1};
	int failures, tests_run, dur;
	emb_ext_bus uut (.clk(clk), .rst(rst), .mode_cfg(mode_cfg),
		.exec_external(exec_external), .sleep(sleep), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .req_valid(req_valid), .req_kind(req_kind),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.req_done(req_done), .rsp_data(rsp_data), .muxed_addr_data_in(ad_w),
		.muxed_addr_data_out(ad_out), .muxed_addr_data_oe_n(ad_oe_n),
		.upper_addr_out(upper_addr_out), .upper_addr_oe_n(upper_addr_oe_n),
		.ctl_out(ctl_out), .ctl_oe_n(ctl_oe_n), .pins_are_port(pins_are_port));
	emb_mem_model mem (.clk(clk), .ad_out(ad_out), .ctl_out(ctl_out),
		.ad_in(m_ad));
	assign ad_w = (ad_oe_n & m_ad) | (~ad_oe_n & ad_out);
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] e, g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic rs(input emb_mode_e m);
		rst <= 1;
		mode_cfg <= m;
		exec_external <= 0;
		sleep <= 0;
		repeat (8) @(posedge clk);
		rst <= 0;
		repeat (4) @(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1;
		@(posedge clk);
		reg_we <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_re <= 1;
		@(posedge clk);
		reg_re <= 0;
		@(posedge clk);
		chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
	endtask
	// Samples every edge of the access; dur runs from latch to done
	task automatic acc(input emb_acc_e k, input logic [20:0] a,
		input logic [7:0] d);
		int n;
		int lat;
		lat = -1;
		c_and = 8'hFF;
		up_s = 8'hFF;
		oe_or = 0;
		while (req_ready !== 1'b1) @(posedge clk);
		req_kind <= k;
		req_addr <= a;
		req_wdata <= d;
		req_valid <= 1;
		for (n = 0; n < 300 && req_done !== 1'b1; n++) begin
			@(posedge clk);
			if (req_ready === 1'b0)
				req_valid <= 0;
			if (ctl_out[CTL_LATCH] === 1'b1 && lat < 0)
				lat = n;
			c_and &= ctl_out;
			if (ctl_out[CTL_LATCH]) begin
				oe_or |= ctl_oe_n[0];
				up_s = {upper_addr_oe_n, upper_addr_out};
			end
			if (!ctl_out[CTL_WR_HI] || !ctl_out[CTL_WR_LO])
				w_ad = ad_out;
		end
		// Latch cycles and the done cycle both counted
		dur = n - lat;
		chk("req_done", 16'h0001, {15'h0000, req_done});
	endtask
	task automatic t_regs();
		rs(EMB_MODE_MPU);
		rd(4'h0, BUS_CTRL_RST);
		wr(4'h0, 8'hFF);
		rd(4'h0, 8'hB3);
		wr(4'h1, 8'h00);
		rd(4'h1, 8'h00);
		rd(4'h0, 8'hB3);
		chk("pins_are_port", 16'h0000, {15'h0000, pins_are_port});
		$display("test regs done");
	endtask
	task automatic t_reads();
		logic [20:0] a;
		for (int c = 0; c < 4; c++) begin
			a = 21'h1_2344 + 21'(c * 2);
			wr(4'h0, {2'b00, 2'(c), 4'h0});
			acc(EMB_ACC_TBLRD, a, 8'h00);
			chk("read cycles", 16'(4 + (4 - c) * 4), 16'(dur));
			chk("rsp_data", ~a[16:1], rsp_data);
		end
		acc(EMB_ACC_FETCH, 21'h1A_0F0E, 8'h00);
		chk("fetch cycles", 16'h0008, 16'(dur));
		chk("upper addr", 16'h000D, {8'h00, up_s});
		chk("strobes", 16'h0000, {14'h0000, c_and[CTL_CHIP], c_and[CTL_OUTEN]});
		$display("test reads done");
	endtask
	task automatic t_writes();
		logic [7:0] d;
		for (int i = 0; i < 6; i++) begin
			d = 8'hA0 + 8'(i);
			wr(4'h0, 8'h30 | 8'(i / 2));
			acc(EMB_ACC_TABLE_WRITE_INSTR, {20'h0_1234, 1'(i)}, d);
			chk("write strobes", {12'h000, exp_s[i]},
				{12'h000, c_and[7], c_and[6], c_and[3], c_and[2]});
			if (i != 4)
				chk("write data", i == 5 ? {d, 8'hA4} : {d, d}, w_ad);
		end
		$display("test writes done");
	endtask
	task automatic t_pins();
		rs(EMB_MODE_BOOT);
		chk("bus pins", 16'h0000, {15'h0000, pins_are_port});
		wr(4'h0, 8'h80);
		repeat (3) @(posedge clk);
		chk("port pins", 16'h0001, {15'h0000, pins_are_port});
		acc(EMB_ACC_FETCH, 21'h0_0100, 8'h00);
		chk("access oe", 16'h0000, {15'h0000, oe_or});
		wr(4'h0, 8'h00);
		exec_external <= 1;
		@(posedge clk);
		wr(4'h0, 8'h80);
		repeat (3) @(posedge clk);
		chk("deferred", 16'h0000, {15'h0000, pins_are_port});
		exec_external <= 0;
		repeat (3) @(posedge clk);
		chk("switched", 16'h0001, {15'h0000, pins_are_port});
		$display("test pins done");
	endtask
	task automatic t_mcu_sleep();
		rs(EMB_MODE_MCU);
		wr(4'h0, 8'hFF);
		rd(4'h0, 8'h00);
		chk("mcu ready", 16'h0000, {15'h0000, req_ready});
		rs(EMB_MODE_MPU);
		sleep <= 1;
		repeat (3) @(posedge clk);
		chk("sleep ready", 16'h0000, {15'h0000, req_ready});
		sleep <= 0;
		$display("test mcu sleep done");
	endtask
	initial begin
		{rst, exec_external, sleep, reg_we, reg_re, req_valid} = 6'h20;
		{reg_addr, reg_wdata, req_wdata, req_addr} = '0;
		mode_cfg = EMB_MODE_MPU;
		req_kind = EMB_ACC_FETCH;
		t_regs();
		t_reads();
		t_writes();
		t_pins();
		t_mcu_sleep();
		complete_run();
	end
	// Whole run needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end
endmodule
